// ---- hdl/sbp_defines.vh ----
`ifndef SBP_DEFINES_VH
`define SBP_DEFINES_VH
// Register byte offsets
`define SBP_OFS_CTRL 8'h00
`define SBP_OFS_ROUTE 8'h04
`define SBP_OFS_STATUS 8'h08
`define SBP_OFS_IRQ_STAT 8'h0C
`define SBP_OFS_IRQ_MASK 8'h10
`define SBP_OFS_IDENT 8'h14
// Control fields
`define SBP_CTRL_SEL0 0
`define SBP_CTRL_SEL1 1
`define SBP_CTRL_IDRD 2
// Reset values
`define SBP_CTRL_RST 32'h00000000
`define SBP_ROUTE_RST 32'h00000000
`define SBP_MASK_RST 32'h00000000
// Arbitrary neutral pod identity value
`define SBP_POD_IDENT 8'h5A
// Interrupt bits
`define SBP_IRQ_EXTERNAL_CAPTURE_CLOCK 0
`define SBP_IRQ_PWR 1
`endif

// ---- hdl/sbp_pod_frontend.v ----
// How it works
// - Target data and address pass buffered toward the capture channels.
// - Data byte latches on data_latch_strobe, from external clock and internal select.
// - Channels 24 to 31 carry user signals routed by configurable jumpers.
// - Routing defaults to the standard bus signal assignment.
// - Mainframe can read a fixed pod identity on channels 24 to 30.
// - target_power_sense is exposed with the identity for attach check.
// - A multiplexer picks sample or external clock under probe select 0 and 1.
// - Selected clock goes back to the mainframe as selected_capture_clock.
// - External clock is the OR of the four thresholded bus strobes.
`timescale 1ns/1ns
`default_nettype none
`include "sbp_defines.vh"
module sbp_pod_frontend (
  // Clock and reset
  input wire aclk,
  input wire aresetn,
  // AXI4-Lite slave
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  // Target bus pins
  input wire [7:0] target_data,
  input wire [15:0] target_addr,
  input wire [7:0] user_signals,
  input wire [7:0] std_bus_signals,
  input wire bus_refresh_strobe_n,
  input wire bus_read_strobe_n,
  input wire bus_write_strobe_n,
  input wire bus_int_ack_strobe_n,
  input wire target_power_sense,
  // Mainframe side
  input wire mainframe_sample_clock,
  input wire buffered_probe_select_0,
  input wire buffered_probe_select_1,
  output reg [7:0] capture_data,
  output reg [15:0] capture_addr,
  output reg [7:0] upper_capture_channels,
  output reg selected_capture_clock,
  output reg data_latch_strobe,
  output reg irq
);

  // Pin synchronisers, two stages each
  localparam NSYNC = 45;
  wire [NSYNC-1:0] pin_raw;
  reg [NSYNC-1:0] s1_q;
  reg [NSYNC-1:0] s2_q;
  assign pin_raw = {target_data, target_addr, user_signals, std_bus_signals,
                    bus_refresh_strobe_n, bus_read_strobe_n, bus_write_strobe_n,
                    bus_int_ack_strobe_n, mainframe_sample_clock};
  always @(posedge aclk) begin
    s1_q <= pin_raw;
    s2_q <= s1_q;
  end
  // Probe selects and power sense
  reg [2:0] m1_q;
  reg [2:0] m2_q;
  always @(posedge aclk) begin
    m1_q <= {target_power_sense, buffered_probe_select_1, buffered_probe_select_0};
    m2_q <= m1_q;
  end

  wire [7:0] data_s = s2_q[44:37];
  wire [15:0] addr_s = s2_q[36:21];
  wire [7:0] user_s = s2_q[20:13];
  wire [7:0] std_s = s2_q[12:5];
  wire [3:0] strobe_n_s = s2_q[4:1];
  wire mclk_s = s2_q[0];
  wire sel0_s = m2_q[0];
  wire sel1_s = m2_q[1];
  wire pwr_s = m2_q[2];

  // Control registers
  reg [31:0] ctrl_q;
  reg [7:0] route_q;
  reg [1:0] irq_stat_q;
  reg [1:0] irq_mask_q;

  // Thresholded strobes OR-combined
  // strobe OR
  wire ext_clk = ~(&strobe_n_s);

  // Internal select and identity enable from mainframe selects or software
  wire sel0 = sel0_s | ctrl_q[`SBP_CTRL_SEL0];
  wire sel1 = sel1_s | ctrl_q[`SBP_CTRL_SEL1];
  wire id_read_enable = (sel0 & sel1) | ctrl_q[`SBP_CTRL_IDRD];
  wire internal_clock_select_n = ~(sel0 & ~sel1);

  wire sel_clk = internal_clock_select_n ? ext_clk : mclk_s;

  reg ext_clk_q;
  reg pwr_q;
  wire ext_rise = ext_clk & ~ext_clk_q;

  wire [7:0] user_route;
  genvar g;
  generate
    for (g = 0; g < 8; g = g + 1) begin : g_route
      assign user_route[g] = route_q[g] ? user_s[g] : std_s[g];
    end
  endgenerate

  // Pod identity word
  wire [7:0] pod_ident = `SBP_POD_IDENT;
  wire [7:0] ident_word = {pwr_s, pod_ident[6:0]};

  // External clock edge history
  always @(posedge aclk) begin
    if (!aresetn)
      ext_clk_q <= 1'b0;
    else
      ext_clk_q <= ext_clk;
  end

  // Power sense history
  always @(posedge aclk) begin
    if (!aresetn)
      pwr_q <= 1'b0;
    else
      pwr_q <= pwr_s;
  end

  always @(posedge aclk) begin
    if (!aresetn)
      capture_addr <= 16'h0000;
    else
      capture_addr <= addr_s;
  end

  wire latch_open = ext_clk & internal_clock_select_n;
  always @(posedge aclk) begin
    if (!aresetn) begin
      data_latch_strobe <= 1'b0;
      capture_data <= 8'h00;
    end else begin
      data_latch_strobe <= latch_open;
      if (latch_open)
        capture_data <= data_s;
    end
  end

  always @(posedge aclk) begin
    if (!aresetn)
      selected_capture_clock <= 1'b0;
    else
      selected_capture_clock <= sel_clk;
  end

  reg [7:0] upper_d;
  always @* begin
    upper_d = user_route;
    if (id_read_enable)
      upper_d = ident_word;
  end
  always @(posedge aclk) begin
    if (!aresetn)
      upper_capture_channels <= 8'h00;
    else
      upper_capture_channels <= upper_d;
  end

  // AXI write channel
  reg aw_got_q;
  reg w_got_q;
  reg [7:0] awaddr_q;
  reg [31:0] wdata_q;
  wire do_write = aw_got_q & w_got_q & ~s_axi_bvalid;
  // Events: bit0 external clock rise, bit1 power change
  wire [1:0] ev = {pwr_s ^ pwr_q, ext_rise};

  // Write address decode
  wire hit_ctrl = awaddr_q == `SBP_OFS_CTRL;
  wire hit_route = awaddr_q == `SBP_OFS_ROUTE;
  wire hit_stat = awaddr_q == `SBP_OFS_IRQ_STAT;
  wire hit_mask = awaddr_q == `SBP_OFS_IRQ_MASK;
  wire hit_ro = (awaddr_q == `SBP_OFS_STATUS) | (awaddr_q == `SBP_OFS_IDENT);
  wire wr_ok = hit_ctrl | hit_route | hit_stat | hit_mask | hit_ro;

  // Address and data capture
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      aw_got_q <= 1'b0;
      w_got_q <= 1'b0;
      awaddr_q <= 8'h00;
      wdata_q <= 32'h00000000;
    end else begin
      s_axi_awready <= ~aw_got_q & ~s_axi_awready & s_axi_awvalid;
      s_axi_wready <= ~w_got_q & ~s_axi_wready & s_axi_wvalid;
      if (s_axi_awvalid & s_axi_awready) begin
        aw_got_q <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid & s_axi_wready) begin
        w_got_q <= 1'b1;
        wdata_q <= s_axi_wdata;
      end
      if (do_write) begin
        aw_got_q <= 1'b0;
        w_got_q <= 1'b0;
      end
    end
  end

  // Write response, refused for unmapped offsets
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'b00;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wr_ok ? 2'b00 : 2'b10;
    end else if (s_axi_bvalid & s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Control fields from written word
  reg [31:0] ctrl_d;
  always @* begin
    ctrl_d = 32'h00000000;
    ctrl_d[`SBP_CTRL_SEL0] = wdata_q[`SBP_CTRL_SEL0];
    ctrl_d[`SBP_CTRL_SEL1] = wdata_q[`SBP_CTRL_SEL1];
    ctrl_d[`SBP_CTRL_IDRD] = wdata_q[`SBP_CTRL_IDRD];
  end

  // Control register
  always @(posedge aclk) begin
    if (!aresetn)
      ctrl_q <= `SBP_CTRL_RST;
    else if (do_write & hit_ctrl)
      ctrl_q <= ctrl_d;
  end

  wire [31:0] route_rst = `SBP_ROUTE_RST;
  always @(posedge aclk) begin
    if (!aresetn)
      route_q <= route_rst[7:0];
    else if (do_write & hit_route)
      route_q <= wdata_q[7:0];
  end

  // Interrupt mask register
  wire [31:0] mask_rst = `SBP_MASK_RST;
  always @(posedge aclk) begin
    if (!aresetn)
      irq_mask_q <= mask_rst[1:0];
    else if (do_write & hit_mask)
      irq_mask_q <= wdata_q[1:0];
  end

  // Sticky event flags, set wins over clear
  reg [1:0] irq_stat_d;
  always @* begin
    irq_stat_d = irq_stat_q;
    if (do_write & hit_stat)
      irq_stat_d = irq_stat_q & ~wdata_q[1:0];
    irq_stat_d = irq_stat_d | ev;
  end
  always @(posedge aclk) begin
    if (!aresetn)
      irq_stat_q <= 2'b00;
    else
      irq_stat_q <= irq_stat_d;
  end

  // Live status word
  wire [4:0] status_word = {id_read_enable, ext_clk, internal_clock_select_n, pwr_s, sel_clk};

  // Read data selection
  reg [31:0] rdata_d;
  reg rd_ok;
  always @* begin
    rdata_d = 32'h00000000;
    rd_ok = 1'b1;
    case (s_axi_araddr)
      `SBP_OFS_CTRL: rdata_d = ctrl_q;
      `SBP_OFS_ROUTE: rdata_d = {24'h000000, route_q};
      `SBP_OFS_STATUS: rdata_d = {27'h0000000, status_word};
      `SBP_OFS_IRQ_STAT: rdata_d = {30'h00000000, irq_stat_q};
      `SBP_OFS_IRQ_MASK: rdata_d = {30'h00000000, irq_mask_q};
      `SBP_OFS_IDENT: rdata_d = {24'h000000, pod_ident};
      default: rd_ok = 1'b0;
    endcase
  end

  // AXI read channel
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= 2'b00;
    end else begin
      s_axi_arready <= ~s_axi_arready & ~s_axi_rvalid & s_axi_arvalid;
      if (s_axi_arvalid & s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rdata_d;
        s_axi_rresp <= rd_ok ? 2'b00 : 2'b10;
      end else if (s_axi_rvalid & s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // Interrupt output
  wire irq_d = |(irq_stat_q & irq_mask_q);
  always @(posedge aclk) begin
    if (!aresetn)
      irq <= 1'b0;
    else
      irq <= irq_d;
  end

endmodule // sbp_pod_frontend
`default_nettype wire

// ---- verif/sbp_pod_frontend_props.sv ----
`timescale 1ns/1ns
`default_nettype none
`include "sbp_defines.vh"
module sbp_pod_frontend_props (
  // Watched ports
  input wire logic aclk, aresetn, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready,
  input wire logic [1:0] s_axi_rresp,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [15:0] target_addr, capture_addr,
  input wire logic [7:0] upper_capture_channels,
  input wire logic target_power_sense, mainframe_sample_clock, selected_capture_clock,
  input wire logic buffered_probe_select_0, buffered_probe_select_1, bus_refresh_strobe_n,
  input wire logic bus_read_strobe_n, bus_write_strobe_n, bus_int_ack_strobe_n
);
  localparam logic [7:0] ID = `SBP_POD_IDENT;
  wire logic p0 = buffered_probe_select_0;
  wire logic idm = p0 & buffered_probe_select_1;
  wire logic intm = p0 & !buffered_probe_select_1;
  wire logic stb = !(bus_refresh_strobe_n & bus_read_strobe_n & bus_write_strobe_n
    & bus_int_ack_strobe_n);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  addr_pass_a: assert property ($past(aresetn,5) |-> capture_addr == $past(target_addr,3))
    else $error("address wrong");
  id_read_a: assert property ($past(aresetn,5) && $past(idm,3) |->
    upper_capture_channels == {$past(target_power_sense,3), ID[6:0]}) else $error("id wrong");
  int_clock_a: assert property ($past(aresetn,5) && $past(intm,3) |->
    selected_capture_clock == $past(mainframe_sample_clock,3)) else $error("int clock wrong");
  ext_clock_a: assert property ($past(aresetn,5) && !$past(p0,3) |->
    selected_capture_clock == $past(stb,3)) else $error("ext clock wrong");
  ar_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("no read answer");
  ar_pulse_a: assert property (s_axi_arready |=> !s_axi_arready) else $error("arready held");
  r_release_a: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("rvalid held");
  refused_zero_a: assert property (s_axi_rvalid && s_axi_rresp == 2'b10 |-> s_axi_rdata == 0)
    else $error("refused data");
endmodule // sbp_pod_frontend_props
bind sbp_pod_frontend sbp_pod_frontend_props u_props (.*);
`default_nettype wire

// ---- verif/sbp_mainframe_model.sv ----
`timescale 1ns/1ns
`default_nettype none
module sbp_mainframe_model (
  // Select mode and lines
  input wire logic [1:0] mode,
  output logic mainframe_sample_clock, buffered_probe_select_0, buffered_probe_select_1
);
  initial begin
    mainframe_sample_clock = 0;
    #7 forever #80 mainframe_sample_clock = ~mainframe_sample_clock;
  end
  assign {buffered_probe_select_1, buffered_probe_select_0} = mode;
endmodule // sbp_mainframe_model
`default_nettype wire

// ---- verif/sbp_pod_frontend_tb.sv ----
`timescale 1ns/1ns
`default_nettype none
`include "sbp_defines.vh"
module sbp_pod_frontend_tb;
  logic aclk = 0, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic s_axi_arvalid = 0, s_axi_rready = 0, target_power_sense = 0;
  logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0, target_data = 0;
  logic [7:0] user_signals = 0, std_bus_signals = 0;
  logic [31:0] s_axi_wdata = 0, lf = 32'h7CD0;
  logic [3:0] s_axi_wstrb = 4'hF, stb = 4'hF;
  logic [15:0] target_addr = 0;
  logic [1:0] mode = 0;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
  wire selected_capture_clock, data_latch_strobe;
  wire mainframe_sample_clock, buffered_probe_select_0, buffered_probe_select_1;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  wire [7:0] capture_data, upper_capture_channels;
  wire [15:0] capture_addr;
  wire bus_refresh_strobe_n = stb[3], bus_read_strobe_n = stb[2];
  wire bus_write_strobe_n = stb[1], bus_int_ack_strobe_n = stb[0];
  int err_total = 0, cmp_count = 0, cyc = 0;
  sbp_pod_frontend dut (.*);
  sbp_mainframe_model u_mf (.*);
  initial forever #10 aclk = ~aclk;
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_total++;
      report_and_stop;
    end
  end
  function automatic logic [31:0] nx(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  task automatic report_and_stop;
    $display("compares %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, g);
    cmp_count++;
    if (g !== e) begin
      err_total++;
      $display("wrong value %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    {s_axi_awaddr, s_axi_wdata} <= {a, d};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
    fork
      begin do @(posedge aclk); while (s_axi_awready !== 1'b1); s_axi_awvalid <= 0; end
      begin do @(posedge aclk); while (s_axi_wready !== 1'b1); s_axi_wvalid <= 0; end
    join
    do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 0;
    chk("bresp", 0, s_axi_bresp);
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] e, input logic [1:0] r, string n);
    @(posedge aclk);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'b11;
    do @(posedge aclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 0;
    do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 0;
    chk(n, e, s_axi_rdata);
    chk("resp", r, s_axi_rresp);
  endtask
  task automatic route_chk(input logic [7:0] r);
    wr(`SBP_OFS_ROUTE, {24'h0, r});
    repeat (4) @(posedge aclk);
    chk("addr", target_addr, capture_addr);
    chk("upper", (user_signals & r) | (std_bus_signals & ~r), upper_capture_channels);
  endtask
  task automatic pulse(input int i);
    stb <= ~(4'h1 << i);
    repeat (6) @(posedge aclk);
    chk("strobe", 1, data_latch_strobe);
    stb <= 4'hF;
    repeat (3) @(posedge aclk);
  endtask
  initial begin
    repeat (16) @(posedge aclk);
    aresetn <= 1;
    rc(`SBP_OFS_CTRL, `SBP_CTRL_RST, 0, "ctrl");
    rc(`SBP_OFS_ROUTE, `SBP_ROUTE_RST, 0, "route");
    rc(`SBP_OFS_IRQ_MASK, `SBP_MASK_RST, 0, "mask");
    wr(`SBP_OFS_IDENT, 32'hFF);
    rc(`SBP_OFS_IDENT, `SBP_POD_IDENT, 0, "ident");
    rc(8'h40, 0, 2'b10, "unmapped");
    repeat (12) begin
      lf = nx(lf);
      {target_data, target_addr, user_signals} <= lf;
      std_bus_signals <= lf[23:16] ^ lf[31:24];
      route_chk(lf[9:2]);
    end
    route_chk(8'hFF);
    route_chk(8'h00);
    mode <= 2'b11;
    for (int p = 0; p < 2; p++) begin
      target_power_sense <= p[0];
      repeat (5) @(posedge aclk);
      chk("id", {p[0], 7'(`SBP_POD_IDENT)}, upper_capture_channels);
    end
    mode <= 0;
    wr(`SBP_OFS_IRQ_MASK, 1);
    for (int i = 0; i < 4; i++) begin
      wr(`SBP_OFS_IRQ_STAT, 3);
      repeat (2) @(posedge aclk);
      chk("irq clear", 0, irq);
      lf = nx(lf);
      target_data <= lf[7:0];
      pulse(i);
      target_data <= ~lf[7:0];
      repeat (4) @(posedge aclk);
      chk("irq", 1, irq);
      chk("latch", lf[7:0], capture_data);
    end
    wr(`SBP_OFS_IRQ_STAT, 3);
    wr(`SBP_OFS_IRQ_MASK, 0);
    pulse(2);
    chk("masked", 0, irq);
    rc(`SBP_OFS_IRQ_STAT, 1, 0, "sticky");
    wr(`SBP_OFS_IRQ_STAT, 1);
    rc(`SBP_OFS_IRQ_STAT, 0, 0, "cleared");
    mode <= 2'b01;
    repeat (300) @(posedge aclk);
    report_and_stop;
  end
endmodule // sbp_pod_frontend_tb
`default_nettype wire
